// File: rtl/fbq_pkg.sv
// constants, carriers and state type for the flash burst and partition query table
// Function
// [R1] page read byte holds n, page is 2^n bytes: 05 separate bus, 00 multiplexed
// [R2] count of synchronous read configuration bytes that follow reads 03
// [R3] configuration byte bits 0-2 hold n, length 2^(n+1); bits 3-7 reserved
// [R4] configuration code 07h means continuous linear burst to end of space
// [R5] host may copy a 3-bit burst code straight into read configuration bits 0-2
// [R6] the three configuration bytes read 02, 03 and 07: 8, 16 words, continuous
// [R7] region count reads zero on single partition devices and no region fields follow; here those addresses still decode and read 00
// [R8] region description starts with two-byte size, counting the size field itself
// [R9] region description holds a two-byte count of identical partitions
// [R10] local concurrency byte: program ops in bits 0-3, erase ops in bits 4-7
// [R11] byte gives ops other partitions may run while this region programs
// [R12] byte gives ops other partitions may run while this region erases
// [R13] every table entry is a fixed read-only byte on the low eight data lines
package fbq_pkg;

   // ****************************************************************
   // bus widths
   // ****************************************************************
   localparam int ADDR_W  = 12;
   localparam int DATA_W  = 32;
   localparam int IDX_W   = ADDR_W - 2;

   // ****************************************************************
   // register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [IDX_W-1:0] IDX_PAGE_READ_SIZE   = 10'h127;
   localparam logic [IDX_W-1:0] IDX_SYNC_COUNT       = 10'h128;
   localparam logic [IDX_W-1:0] IDX_SYNC_CFG_ONE     = 10'h129;
   localparam logic [IDX_W-1:0] IDX_SYNC_CFG_TWO     = 10'h12A;
   localparam logic [IDX_W-1:0] IDX_SYNC_CFG_THREE   = 10'h12B;
   localparam logic [IDX_W-1:0] IDX_REGION_COUNT     = 10'h12C;
   localparam logic [IDX_W-1:0] IDX_REGION_SIZE_LO   = 10'h12D;
   localparam logic [IDX_W-1:0] IDX_REGION_SIZE_HI   = 10'h12E;
   localparam logic [IDX_W-1:0] IDX_IDENT_PART_LO    = 10'h12F;
   localparam logic [IDX_W-1:0] IDX_IDENT_PART_HI    = 10'h130;
   localparam logic [IDX_W-1:0] IDX_LOCAL_CONC       = 10'h131;
   localparam logic [IDX_W-1:0] IDX_CONC_PROGRAM     = 10'h132;
   localparam logic [IDX_W-1:0] IDX_CONC_ERASE       = 10'h133;
   localparam logic [IDX_W-1:0] IDX_READ_CONFIG      = 10'h140;
   localparam logic [IDX_W-1:0] IDX_BURST_STATUS     = 10'h141;

   // ****************************************************************
   // fixed table values and field layout
   // ****************************************************************
   localparam logic [7:0] PAGE_CODE_SEPARATE   = 8'h05;
   localparam logic [7:0] PAGE_CODE_MUX        = 8'h00;
   localparam logic [7:0] SYNC_CFG_COUNT       = 8'h03;
   localparam int         BURST_CODE_W         = 3;
   localparam logic [2:0] BURST_CODE_ONE       = 3'h2;
   localparam logic [2:0] BURST_CODE_TWO       = 3'h3;
   localparam logic [2:0] BURST_CODE_THREE     = 3'h7;
   localparam logic [2:0] BURST_CODE_CONT      = 3'h7;
   localparam int         PROG_LSB             = 0;
   localparam int         ERASE_LSB            = 4;
   localparam int         STAT_CONT_BIT        = 3;
   localparam int         STAT_LEN_LSB         = 8;
   localparam logic [2:0] READ_CONFIG_RESET    = 3'h7;

   // ****************************************************************
   // response codes
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic [2:0]        awprot;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic [2:0]        arprot;
      logic              rready;
   } fbq_axi_req_type;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } fbq_axi_rsp_type;

   typedef struct packed {
      logic [2:0] code;
      logic       continuous;
      logic [7:0] length_words;
   } fbq_burst_type;

   typedef struct packed {
      logic            aw_held;
      logic [IDX_W-1:0] aw_idx;
      logic            w_held;
      logic [7:0]      w_byte;
      logic            w_lane0;
      fbq_axi_rsp_type rsp;
      logic [2:0]      read_config;
      fbq_burst_type   burst;
   } fbq_state_type;

   localparam fbq_burst_type BURST_RESET = '{code: 3'h7, continuous: 1'b1, length_words: 8'h00};

endpackage : fbq_pkg

// File: rtl/fbq_query_rom.sv
// query table for burst read and partition region facts, read over AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module fbq_query_rom #(
   parameter bit         SEPARATE_AD        = 1'b1,
   parameter logic [7:0] REGION_COUNT       = 8'h01,
   parameter logic [15:0] REGION_INFO_SIZE  = 16'h0011,
   parameter logic [15:0] IDENT_PARTITIONS  = 16'h0001,
   parameter logic [3:0] LOCAL_PROG_OPS     = 4'h1,
   parameter logic [3:0] LOCAL_ERASE_OPS    = 4'h1,
   parameter logic [3:0] DURING_PROG_PROG   = 4'h1,
   parameter logic [3:0] DURING_PROG_ERASE  = 4'h1,
   parameter logic [3:0] DURING_ERASE_PROG  = 4'h1,
   parameter logic [3:0] DURING_ERASE_ERASE = 4'h1
) (
   // clock, reset, enable
   input  wire logic                     ref_clk_i,
   input  wire logic                     reset_i,
   input  wire logic                     clk_en_i,
   // register bus
   input  wire fbq_pkg::fbq_axi_req_type axi_req_i,
   output      fbq_pkg::fbq_axi_rsp_type axi_rsp_o,
   // burst setting towards the read path
   output      fbq_pkg::fbq_burst_type   burst_o
);
   import fbq_pkg::*;

   // ****************************************************************
   // decoding helpers
   // ****************************************************************
   typedef struct packed {
      logic        hit;
      logic        writable;
      logic [DATA_W-1:0] data;
   } fbq_lookup_type;

   function automatic fbq_burst_type burst_decode(input logic [2:0] code);
      fbq_burst_type b;
      b.code = code;
      b.continuous = (code == BURST_CODE_CONT);                                 // [R4]
      if (b.continuous) begin
         b.length_words = 8'h00;
      end else begin
         b.length_words = 8'(16'h0001 << ({1'b0, code} + 4'h1));                // [R3]
      end
      return b;
   endfunction : burst_decode

   function automatic logic [7:0] nibble_pair(input logic [3:0] prog, input logic [3:0] erase);
      logic [7:0] v;
      v = 8'h00;
      v[PROG_LSB +: 4] = prog;
      v[ERASE_LSB +: 4] = erase;
      return v;
   endfunction : nibble_pair

   // one lookup serves both the read path and the write permission check
   function automatic fbq_lookup_type lookup(input logic [IDX_W-1:0] idx,
                                             input logic [2:0] rcfg,
                                             input fbq_burst_type b);
      fbq_lookup_type l;
      logic [7:0] entry;
      logic       region_field;
      entry = 8'h00;
      region_field = 1'b0;
      l.hit = 1'b1;
      l.writable = 1'b0;
      l.data = '0;
      unique case (idx)
         IDX_PAGE_READ_SIZE: begin
            entry = SEPARATE_AD ? PAGE_CODE_SEPARATE : PAGE_CODE_MUX;           // [R1]
         end
         IDX_SYNC_COUNT: begin
            entry = SYNC_CFG_COUNT;                                             // [R2]
         end
         IDX_SYNC_CFG_ONE: begin
            entry = {5'h00, BURST_CODE_ONE};                                    // [R3] [R6]
         end
         IDX_SYNC_CFG_TWO: begin
            entry = {5'h00, BURST_CODE_TWO};                                    // [R3] [R6]
         end
         IDX_SYNC_CFG_THREE: begin
            entry = {5'h00, BURST_CODE_THREE};                                  // [R4] [R6]
         end
         IDX_REGION_COUNT: begin
            entry = REGION_COUNT;                                               // [R7]
         end
         IDX_REGION_SIZE_LO: begin
            entry = REGION_INFO_SIZE[7:0];                                      // [R8]
            region_field = 1'b1;
         end
         IDX_REGION_SIZE_HI: begin
            entry = REGION_INFO_SIZE[15:8];                                     // [R8]
            region_field = 1'b1;
         end
         IDX_IDENT_PART_LO: begin
            entry = IDENT_PARTITIONS[7:0];                                      // [R9]
            region_field = 1'b1;
         end
         IDX_IDENT_PART_HI: begin
            entry = IDENT_PARTITIONS[15:8];                                     // [R9]
            region_field = 1'b1;
         end
         IDX_LOCAL_CONC: begin
            entry = nibble_pair(LOCAL_PROG_OPS, LOCAL_ERASE_OPS);               // [R10]
            region_field = 1'b1;
         end
         IDX_CONC_PROGRAM: begin
            entry = nibble_pair(DURING_PROG_PROG, DURING_PROG_ERASE);           // [R11]
            region_field = 1'b1;
         end
         IDX_CONC_ERASE: begin
            entry = nibble_pair(DURING_ERASE_PROG, DURING_ERASE_ERASE);         // [R12]
            region_field = 1'b1;
         end
         IDX_READ_CONFIG: begin
            l.writable = 1'b1;
            l.data[BURST_CODE_W-1:0] = rcfg;                                    // [R5]
         end
         IDX_BURST_STATUS: begin
            l.data[BURST_CODE_W-1:0] = b.code;
            l.data[STAT_CONT_BIT] = b.continuous;
            l.data[STAT_LEN_LSB +: 8] = b.length_words;
         end
         default: begin
            l.hit = 1'b0;
         end
      endcase
      // a single partition device still decodes its region fields behind the count, and they read 00
      if (region_field && (REGION_COUNT == 8'h00)) begin
         entry = 8'h00;                                                         // [R7]
      end
      if (!l.writable && (idx != IDX_BURST_STATUS)) begin
         l.data[7:0] = entry;                                                   // [R13]
      end
      return l;
   endfunction : lookup

   // ****************************************************************
   // state
   // ****************************************************************
   localparam fbq_axi_rsp_type RSP_RESET = '{awready: 1'b1, wready: 1'b1, bvalid: 1'b0,
                                             bresp: RESP_OKAY, arready: 1'b1, rvalid: 1'b0,
                                             rdata: '0, rresp: RESP_OKAY};
   localparam fbq_state_type STATE_RESET = '{aw_held: 1'b0, aw_idx: '0, w_held: 1'b0,
                                             w_byte: 8'h00, w_lane0: 1'b0, rsp: RSP_RESET,
                                             read_config: READ_CONFIG_RESET,
                                             burst: BURST_RESET};

   fbq_state_type state_q;
   fbq_state_type state_d;
   fbq_lookup_type wr_look;
   fbq_lookup_type rd_look;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      state_d = state_q;
      wr_look = lookup(state_q.aw_idx, state_q.read_config, state_q.burst);
      rd_look = lookup(axi_req_i.araddr[ADDR_W-1:2], state_q.read_config, state_q.burst);

      // address and data are taken independently, in either order
      if (state_q.rsp.awready && axi_req_i.awvalid) begin
         state_d.aw_held = 1'b1;
         state_d.aw_idx = axi_req_i.awaddr[ADDR_W-1:2];
         state_d.rsp.awready = 1'b0;
         wr_look = lookup(axi_req_i.awaddr[ADDR_W-1:2], state_q.read_config, state_q.burst);
      end
      if (state_q.rsp.wready && axi_req_i.wvalid) begin
         state_d.w_held = 1'b1;
         state_d.w_byte = axi_req_i.wdata[7:0];
         state_d.w_lane0 = axi_req_i.wstrb[0];
         state_d.rsp.wready = 1'b0;
      end

      // response goes out once both halves are in; readies stay low until it is taken
      if (state_q.rsp.bvalid && axi_req_i.bready) begin
         state_d.rsp.bvalid = 1'b0;
         state_d.rsp.awready = 1'b1;
         state_d.rsp.wready = 1'b1;
      end else if (state_d.aw_held && state_d.w_held) begin
         state_d.aw_held = 1'b0;
         state_d.w_held = 1'b0;
         state_d.rsp.bvalid = 1'b1;
         if (wr_look.writable) begin
            state_d.rsp.bresp = RESP_OKAY;
            if (state_d.w_lane0) begin
               state_d.read_config = state_d.w_byte[BURST_CODE_W-1:0];          // [R5]
            end
         end else if (wr_look.hit) begin
            state_d.rsp.bresp = RESP_SLVERR;                                    // [R13]
         end else begin
            state_d.rsp.bresp = RESP_DECERR;
         end
      end
      state_d.burst = burst_decode(state_d.read_config);                        // [R5]

      // reads: one outstanding, answered one edge after the address is taken
      if (state_q.rsp.rvalid && axi_req_i.rready) begin
         state_d.rsp.rvalid = 1'b0;
         state_d.rsp.arready = 1'b1;
      end
      if (state_q.rsp.arready && axi_req_i.arvalid) begin
         state_d.rsp.arready = 1'b0;
         state_d.rsp.rvalid = 1'b1;
         state_d.rsp.rdata = rd_look.hit ? rd_look.data : '0;
         state_d.rsp.rresp = rd_look.hit ? RESP_OKAY : RESP_DECERR;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   // a low enable freezes the bus too, so handshakes simply stretch
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= STATE_RESET;
      end else if (clk_en_i) begin
         state_q <= state_d;
      end
   end

   assign axi_rsp_o = state_q.rsp;
   assign burst_o   = state_q.burst;

endmodule : fbq_query_rom

// File: testbench/fbq_host_model.sv
// host controller model: AXI4-Lite master reading and writing the query table
`timescale 1ns/1ps
module fbq_host_model (
   // clock and shared clock enable
   input  wire logic                     ref_clk_i,
   input  wire logic                     clk_en_i,
   // register bus
   output      fbq_pkg::fbq_axi_req_type axi_req_o,
   input  wire fbq_pkg::fbq_axi_rsp_type axi_rsp_i
);
   import fbq_pkg::*;
   initial axi_req_o = '0;
   // ********
   // lag holds rready low for a while to stretch the answer
   // ********
   // the host sits in the same enabled domain, so only enabled edges count as handshakes
   task automatic rd(input logic [11:0] addr, input int lag, output logic [31:0] data,
                     output logic [1:0] resp);
      int n;
      n = lag;
      @(posedge ref_clk_i);
      axi_req_o.arvalid <= 1'b1;
      axi_req_o.araddr  <= addr;
      axi_req_o.rready  <= (lag == 0);
      forever begin
         @(posedge ref_clk_i iff clk_en_i);
         if (axi_req_o.arvalid && axi_rsp_i.arready) axi_req_o.arvalid <= 1'b0;
         if (axi_req_o.rready && axi_rsp_i.rvalid) begin
            data = axi_rsp_i.rdata;
            resp = axi_rsp_i.rresp;
            axi_req_o.rready <= 1'b0;
            break;
         end
         if (n > 1) n--;
         else axi_req_o.rready <= 1'b1;
      end
   endtask : rd
   task automatic wr(input logic [11:0] addr, input logic [31:0] data, input logic [3:0] strb,
                     output logic [1:0] resp);
      @(posedge ref_clk_i);
      axi_req_o.awvalid <= 1'b1;
      axi_req_o.awaddr  <= addr;
      axi_req_o.wvalid  <= 1'b1;
      axi_req_o.wdata   <= data;
      axi_req_o.wstrb   <= strb;
      axi_req_o.bready  <= 1'b1;
      forever begin
         @(posedge ref_clk_i iff clk_en_i);
         if (axi_rsp_i.awready) axi_req_o.awvalid <= 1'b0;
         if (axi_rsp_i.wready) axi_req_o.wvalid <= 1'b0;
         if (axi_rsp_i.bvalid) begin
            resp = axi_rsp_i.bresp;
            axi_req_o.bready <= 1'b0;
            break;
         end
      end
   endtask : wr
endmodule : fbq_host_model

// File: testbench/fbq_query_rom_checker.sv
// bus and burst-setting assertions for the query table
`timescale 1ns/1ps
module fbq_query_rom_checker (
   // clock, reset, enable
   input  wire logic                     ref_clk_i,
   input  wire logic                     reset_i,
   input  wire logic                     clk_en_i,
   // observed ports
   input  wire fbq_pkg::fbq_axi_req_type axi_req_i,
   input  wire fbq_pkg::fbq_axi_rsp_type axi_rsp_o,
   input  wire fbq_pkg::fbq_burst_type   burst_o
);
   import fbq_pkg::*;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   // ********
   // handshakes taken this edge
   // ********
   wire logic ar_go = axi_req_i.arvalid & axi_rsp_o.arready & clk_en_i;
   wire logic wr_go = axi_req_i.awvalid & axi_rsp_o.awready & axi_req_i.wvalid
                      & axi_rsp_o.wready & clk_en_i;
   property p_rd_hold; axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
   property p_rd_byte; ar_go && axi_req_i.araddr[11:8] == 4'h4 |=> axi_rsp_o.rdata[31:8] == 24'h0; endproperty
   a_rd_byte: assert property (p_rd_byte) else $error("table byte not on low lanes");
   property p_count; ar_go && axi_req_i.araddr == 12'h4A0 |=> axi_rsp_o.rdata == 32'h3; endproperty
   a_count: assert property (p_count) else $error("config count wrong");
   property p_cfg3; ar_go && axi_req_i.araddr == 12'h4AC |=> axi_rsp_o.rdata == 32'h7; endproperty
   a_cfg3: assert property (p_cfg3) else $error("third config byte wrong");
   property p_wr_ro; wr_go && axi_req_i.awaddr >= 12'h49C && axi_req_i.awaddr <= 12'h4CC
      |=> axi_rsp_o.bvalid && axi_rsp_o.bresp == RESP_SLVERR; endproperty
   a_wr_ro: assert property (p_wr_ro) else $error("table write not refused");
   property p_cont; burst_o.continuous |-> burst_o.code == 3'h7 && burst_o.length_words == 8'h00; endproperty
   a_cont: assert property (p_cont) else $error("continuous flag wrong");
   property p_len; !burst_o.continuous |-> burst_o.length_words == (8'h01 << (burst_o.code + 3'h1)); endproperty
   a_len: assert property (p_len) else $error("burst length wrong");
   property p_copy; wr_go && axi_req_i.awaddr == 12'h500 && axi_req_i.wstrb[0] |=> burst_o.code == $past(axi_req_i.wdata[2:0]); endproperty
   a_copy: assert property (p_copy) else $error("burst code not copied");
   property p_unmap; ar_go && axi_req_i.araddr == 12'h000 |=> axi_rsp_o.rresp == RESP_DECERR && axi_rsp_o.rdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
   c_slow_read: cover property (axi_rsp_o.rvalid && !axi_req_i.rready);
   c_ro_write: cover property (wr_go && axi_req_i.awaddr[11:8] == 4'h4);
   c_fixed_len: cover property (!burst_o.continuous);
endmodule : fbq_query_rom_checker
bind fbq_query_rom fbq_query_rom_checker u_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
   .clk_en_i(clk_en_i), .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .burst_o(burst_o));

// File: testbench/tb.sv
// self-checking bench for the burst and partition query table
`timescale 1ns/1ps
module tb;
   import fbq_pkg::*;
   logic            ref_clk_i   = 1'b0;
   logic            reset_i     = 1'b1;
   logic            clk_en_i    = 1'b1;
   fbq_axi_req_type axi_req;
   fbq_axi_rsp_type axi_rsp;
   fbq_burst_type   burst;
   fbq_axi_rsp_type axi_rsp_mux;
   fbq_burst_type   burst_mux;
   int              mismatches  = 0;
   int              check_count = 0;
   logic [31:0]     d;
   logic [1:0]      r;
   always #5 ref_clk_i = ~ref_clk_i;
   // erase nibbles differ from program nibbles so a swapped field shows up
   fbq_query_rom #(.LOCAL_ERASE_OPS(4'h2), .DURING_PROG_ERASE(4'h4),
      .DURING_ERASE_ERASE(4'h6)) dut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .axi_req_i(axi_req),
      .axi_rsp_o(axi_rsp), .burst_o(burst));
   // multiplexed-bus, single-partition variant shadows the same bus in lockstep
   fbq_query_rom #(.SEPARATE_AD(1'b0), .REGION_COUNT(8'h00)) dut_mux (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .axi_req_i(axi_req),
      .axi_rsp_o(axi_rsp_mux), .burst_o(burst_mux));
   fbq_host_model host (.ref_clk_i(ref_clk_i), .clk_en_i(clk_en_i), .axi_req_o(axi_req),
      .axi_rsp_i(axi_rsp));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // ********
   // scenarios
   // ********
   task automatic t_reset;
      @(negedge ref_clk_i);
      chk("burst after reset", {20'h0, burst}, {20'h0, 3'h7, 1'b1, 8'h00});
   endtask : t_reset
   task automatic t_table;
      logic [7:0] exp [13] = '{8'h05, 8'h03, 8'h02, 8'h03, 8'h07, 8'h01, 8'h11, 8'h00,
                               8'h01, 8'h00, 8'h21, 8'h41, 8'h61};
      logic [7:0] exp_mux [13] = '{8'h00, 8'h03, 8'h02, 8'h03, 8'h07, 8'h00, 8'h00, 8'h00,
                                   8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 13; i++) begin
         host.rd(12'h49C + 12'(i * 4), i % 3, d, r);
         chk("table byte", d, {24'h0, exp[i]});
         chk("table resp", {30'h0, r}, {30'h0, RESP_OKAY});
         @(negedge ref_clk_i);
         chk("variant byte", axi_rsp_mux.rdata, {24'h0, exp_mux[i]});
      end
   endtask : t_table
   task automatic t_ro_write;
      host.wr(12'h4A4, 32'hFFFF_FFFF, 4'hF, r);
      chk("table write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      host.rd(12'h4A4, 0, d, r);
      chk("table entry kept", d, 32'h02);
   endtask : t_ro_write
   task automatic t_burst;
      logic [7:0] len;
      logic [2:0] k;
      for (int c = 0; c < 8; c++) begin
         k = c[2:0];
         len = (k == 3'h7) ? 8'h00 : 8'h01 << (k + 3'h1);
         host.wr(12'h500, {24'hFF_FFFF, 5'h0, k}, 4'hF, r);
         @(negedge ref_clk_i);
         chk("burst setting", {20'h0, burst}, {20'h0, k, k == 3'h7, len});
         chk("variant burst", {20'h0, burst_mux}, {20'h0, k, k == 3'h7, len});
         host.rd(12'h504, 0, d, r);
         chk("burst status", d, {16'h0, len, 4'h0, k == 3'h7, k});
      end
      // the host copies each advertised code straight into the read configuration
      for (int i = 0; i < 3; i++) begin
         host.rd(12'h4A4 + 12'(i * 4), 0, d, r);
         host.wr(12'h500, d, 4'h1, r);
         @(negedge ref_clk_i);
         chk("copied length", {24'h0, burst.length_words}, (i == 2) ? 32'd0 : 32'd8 << i);
      end
   endtask : t_burst
   task automatic t_refused;
      host.wr(12'h500, 32'h0, 4'hE, r);
      @(negedge ref_clk_i);
      chk("masked write keeps code", {29'h0, burst.code}, 32'h7);
      host.rd(12'h000, 1, d, r);
      chk("unmapped read resp", {30'h0, r}, {30'h0, RESP_DECERR});
      chk("unmapped read data", d, 32'h0);
      host.wr(12'h000, 32'h1, 4'hF, r);
      chk("unmapped write resp", {30'h0, r}, {30'h0, RESP_DECERR});
   endtask : t_refused
   // a request offered while the enable is low must wait until it returns
   task automatic t_freeze;
      @(posedge ref_clk_i);
      clk_en_i <= 1'b0;
      fork
         host.rd(12'h4A0, 0, d, r);
         begin
            repeat (4) @(posedge ref_clk_i);
            @(negedge ref_clk_i);
            chk("frozen read answered", {31'h0, axi_rsp.rvalid}, 32'h0);
            @(posedge ref_clk_i);
            clk_en_i <= 1'b1;
         end
      join
      chk("read after freeze", d, 32'h03);
   endtask : t_freeze
   initial begin
      repeat (3) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      t_reset;
      t_table;
      t_ro_write;
      t_burst;
      t_refused;
      t_freeze;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      mismatches++;
      report_and_stop;
   end
endmodule : tb
